/* core/fpec_ctrl.sv */
// Flash program/erase control registers: mode control, error status, block select and access enable.
`timescale 1ns/10ps

module fpec_ctrl
  import fpec_pkg::*;
(
  input  wire logic                    clock,
  input  wire logic                    rst,
  input  wire logic [1:0]              addr,
  input  wire logic [7:0]              wdata,
  input  wire logic                    wr,
  input  wire logic                    rd,
  output logic      [7:0]              rdata,
  input  wire logic                    flash_error,
  output fpec_flash_mode_type          flash_mode,
  output logic      [FPEC_NUM_BLOCKS-1:0] block_select,
  output logic                         prog_erase_enable,
  output logic                         error_protect
);

  fpec_bus_req_type req;
  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  logic [7:0] mode_reg;
  logic [7:0] mode_next;
  logic [7:0] block_reg;
  logic [7:0] block_next;
  logic       access_reg;
  logic       error_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  fpec_flash_mode_type flash_mode_reg;
  fpec_flash_mode_type flash_mode_next;
  logic       enable_reg;

  wire ctrl_open      = access_reg;
  wire sel_mode       = req.addr == FPEC_ADDR_MODE_CONTROL;
  wire sel_status     = req.addr == FPEC_ADDR_ERROR_STATUS;
  wire sel_block      = req.addr == FPEC_ADDR_BLOCK_SELECT;
  wire sel_access     = req.addr == FPEC_ADDR_ACCESS_ENABLE;
  wire wr_mode        = req.wr && sel_mode && ctrl_open;
  wire wr_block       = req.wr && sel_block && ctrl_open;
  wire wr_access      = req.wr && sel_access;
  wire wr_status_drop = req.wr && sel_status;

  wire swe_now        = mode_reg[FPEC_BIT_WRITE_ENABLE];
  wire swe_new        = req.wdata[FPEC_BIT_WRITE_ENABLE];

  wire [7:0] mode_wr_val = swe_new ? (req.wdata & FPEC_MODE_WRITE_MASK) : FPEC_ZERO_BYTE;
  assign mode_next = wr_mode ? mode_wr_val : mode_reg;

  wire [7:0] blk_wr_val  = req.wdata & FPEC_BLOCK_WRITE_MASK;
  wire       blk_multi   = (blk_wr_val & (blk_wr_val - 8'h01)) != FPEC_ZERO_BYTE;
  wire       swe_after   = mode_next[FPEC_BIT_WRITE_ENABLE];
  assign block_next = !swe_after ? FPEC_ZERO_BYTE :
                      wr_block   ? (blk_multi ? FPEC_ZERO_BYTE : blk_wr_val) :
                      block_reg;

  wire en_next = swe_after && !error_reg;

  always_comb begin
    flash_mode_next = '0;
    flash_mode_next.program_setup  = en_next && mode_next[FPEC_BIT_PROGRAM_SETUP];
    flash_mode_next.erase_setup    = en_next && mode_next[FPEC_BIT_ERASE_SETUP];
    flash_mode_next.program_verify = en_next && mode_next[FPEC_BIT_PROGRAM_VERIFY];
    flash_mode_next.erase_verify   = en_next && mode_next[FPEC_BIT_ERASE_VERIFY];
    flash_mode_next.program_mode   = en_next && mode_next[FPEC_BIT_PROGRAM] && mode_next[FPEC_BIT_PROGRAM_SETUP];
    flash_mode_next.erase_mode     = en_next && mode_next[FPEC_BIT_ERASE] && mode_next[FPEC_BIT_ERASE_SETUP];
  end

  wire [7:0] rd_mode   = ctrl_open ? (mode_reg & FPEC_MODE_WRITE_MASK) : FPEC_ZERO_BYTE;
  wire [7:0] rd_status = ctrl_open ? {error_reg, 7'h00} : FPEC_ZERO_BYTE;
  wire [7:0] rd_block  = ctrl_open ? (block_reg & FPEC_BLOCK_WRITE_MASK) : FPEC_ZERO_BYTE;
  wire [7:0] rd_access = {access_reg, 7'h00};
  assign rdata_next = !req.rd   ? FPEC_ZERO_BYTE :
                      sel_mode  ? rd_mode :
                      sel_status? rd_status :
                      sel_block ? rd_block : rd_access;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_reg       <= 8'h00;
      block_reg      <= 8'h00;
      access_reg     <= 1'b0;
      rdata_reg      <= 8'h00;
      flash_mode_reg <= '0;
      enable_reg     <= 1'b0;
    end else begin
      mode_reg       <= mode_next;
      block_reg      <= block_next;
      rdata_reg      <= rdata_next;
      flash_mode_reg <= flash_mode_next;
      enable_reg     <= en_next;
      if (wr_access) begin
        access_reg <= req.wdata[FPEC_BIT_CTRL_ACCESS_EN];
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      error_reg <= 1'b0;
    end else if (flash_error && (flash_mode_reg.program_mode || flash_mode_reg.erase_mode)) begin
      error_reg <= 1'b1;
    end
  end

  // Error protection drops every active mode; the flag itself keeps them down until reset.
  assign rdata             = rdata_reg;
  assign flash_mode        = flash_mode_reg;
  assign block_select      = block_reg[FPEC_NUM_BLOCKS-1:0];
  assign prog_erase_enable = enable_reg;
  assign error_protect     = error_reg;

  wire unused_ok = wr_status_drop;

endmodule // fpec_ctrl

/* core/fpec_pkg.sv */
// Package with register map, field positions and types for the flash program/erase control block.
package fpec_pkg;

  localparam logic [1:0] FPEC_ADDR_MODE_CONTROL = 2'h0;
  localparam logic [1:0] FPEC_ADDR_ERROR_STATUS = 2'h1;
  localparam logic [1:0] FPEC_ADDR_BLOCK_SELECT = 2'h2;
  localparam logic [1:0] FPEC_ADDR_ACCESS_ENABLE = 2'h3;

  localparam int FPEC_BIT_PROGRAM         = 0;
  localparam int FPEC_BIT_ERASE           = 1;
  localparam int FPEC_BIT_PROGRAM_VERIFY  = 2;
  localparam int FPEC_BIT_ERASE_VERIFY    = 3;
  localparam int FPEC_BIT_PROGRAM_SETUP   = 4;
  localparam int FPEC_BIT_ERASE_SETUP     = 5;
  localparam int FPEC_BIT_WRITE_ENABLE    = 6;
  localparam int FPEC_BIT_ERROR_FLAG      = 7;
  localparam int FPEC_BIT_CTRL_ACCESS_EN  = 7;

  localparam logic [7:0] FPEC_MODE_WRITE_MASK  = 8'h7F;
  localparam logic [7:0] FPEC_BLOCK_WRITE_MASK = 8'h3F;
  localparam logic [7:0] FPEC_ZERO_BYTE        = 8'h00;
  localparam int         FPEC_NUM_BLOCKS       = 6;

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } fpec_bus_req_type;

  typedef struct packed {
    logic program_setup;
    logic program_mode;
    logic program_verify;
    logic erase_setup;
    logic erase_mode;
    logic erase_verify;
  } fpec_flash_mode_type;

endpackage

/* tb/fpec_ctrl_asserts.sv */
// Port checker for the flash program/erase control block.
`timescale 1ns/10ps
module fpec_ctrl_asserts
  import fpec_pkg::*;
(
  input wire logic                clock,
  input wire logic                rst,
  input wire logic [1:0]          addr,
  input wire logic                rd,
  input wire logic [7:0]          rdata,
  input wire logic                flash_error,
  input wire fpec_flash_mode_type flash_mode,
  input wire logic [5:0]          block_select,
  input wire logic                prog_erase_enable,
  input wire logic                error_protect
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence stat_rd;
    rd && addr == FPEC_ADDR_ERROR_STATUS;
  endsequence
  sequence err_held;
    error_protect [*2];
  endsequence
  err_sticky_a: assert property (error_protect |=> error_protect) else $error("flag cleared");
  err_set_a: assert property (flash_error && (flash_mode.program_mode || flash_mode.erase_mode)
    |=> error_protect) else $error("flag not set");
  err_block_a: assert property (err_held |-> flash_mode == '0 && !prog_erase_enable) else $error("not protected");
  prog_mode_a: assert property (flash_mode.program_mode |-> flash_mode.program_setup && prog_erase_enable)
    else $error("bad program mode");
  erase_mode_a: assert property (flash_mode.erase_mode |-> flash_mode.erase_setup && prog_erase_enable)
    else $error("bad erase mode");
  blk_onehot_a: assert property ($onehot0(block_select)) else $error("several blocks");
  blk_hold_a: assert property (!prog_erase_enable && !error_protect |-> block_select == '0)
    else $error("block not held");
  stat_zero_a: assert property (stat_rd |=> rdata[6:0] == 7'h00) else $error("status bits set");
  rd_idle_a: assert property (!rd |=> rdata == 8'h00) else $error("read data without read");
endmodule // fpec_ctrl_asserts
bind fpec_ctrl fpec_ctrl_asserts i_chk (.clock(clock), .rst(rst), .addr(addr), .rd(rd), .rdata(rdata),
  .flash_error(flash_error), .flash_mode(flash_mode), .block_select(block_select),
  .prog_erase_enable(prog_erase_enable), .error_protect(error_protect));

/* tb/tb_flash_program_erase_control.sv */
// Self-checking bench for the flash program/erase control registers.
`timescale 1ns/10ps
module tb_flash_program_erase_control;
  import fpec_pkg::*;
  logic                clock = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, flash_error = 1'b0, pe_en, err;
  logic [1:0]          addr = 2'h0;
  logic [7:0]          wdata = 8'h00, rdata;
  logic [5:0]          blk;
  fpec_flash_mode_type mode;
  int                  n_fail = 0, cmp_count = 0;
  logic [7:0]          wtab [7] = '{8'h50, 8'h51, 8'h44, 8'h48, 8'h60, 8'h62, 8'h42};
  logic [7:0]          mtab [7] = '{8'h20, 8'h30, 8'h08, 8'h01, 8'h04, 8'h06, 8'h00};
  fpec_ctrl i_dut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .flash_error(flash_error), .flash_mode(mode), .block_select(blk), .prog_erase_enable(pe_en), .error_protect(err));
  always #12.5 clock = ~clock;
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wreg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rreg(input logic [1:0] a, input logic [7:0] e);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  task automatic stop_test;
    $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) rreg(2'(i), 8'h00);
    wreg(2'h0, 8'h50);
    rreg(2'h0, 8'h00);
    wreg(2'h3, 8'hFF);
    rreg(2'h3, 8'h80);
    wreg(2'h0, 8'h30);
    rreg(2'h0, 8'h00);
    wreg(2'h2, 8'h01);
    rreg(2'h2, 8'h00);
    $display("guard test done");
    wreg(2'h0, 8'h40);
    chk({7'h00, pe_en}, 8'h01);
    for (int i = 0; i < 6; i++) begin
      wreg(2'h2, 8'h01 << i);
      rreg(2'h2, 8'h01 << i);
      chk({2'h0, blk}, 8'h01 << i);
    end
    wreg(2'h2, 8'h03);
    rreg(2'h2, 8'h00);
    wreg(2'h2, 8'h20);
    wreg(2'h0, 8'h00);
    chk({2'h0, blk}, 8'h00);
    // setup bits go in before the strobe bits, as software must; the last write keeps the erase bit without erase setup and expects no mode.
    // Program units are the software's business; the bench writes no array data.
    for (int i = 0; i < 7; i++) begin
      wreg(2'h0, wtab[i]);
      chk({2'h0, mode}, mtab[i]);
      if (i < 6) rreg(2'h0, wtab[i]);
    end
    $display("mode test done");
    wreg(2'h0, 8'h51);
    @(posedge clock);
    flash_error <= 1'b1;
    @(posedge clock);
    flash_error <= 1'b0;
    rreg(2'h1, 8'h80);
    chk({2'h0, mode}, 8'h00);
    chk({7'h00, err}, 8'h01);
    chk({7'h00, pe_en}, 8'h00);
    wreg(2'h1, 8'h00);
    rreg(2'h1, 8'h80);
    chk({7'h00, err}, 8'h01);
    wreg(2'h3, 8'h00);
    rreg(2'h1, 8'h00);
    $display("error test done");
    stop_test;
  end
  initial begin
    repeat (1000) @(posedge clock);
    n_fail++;
    stop_test;
  end
endmodule // tb_flash_program_erase_control
